/* File: design/drm_dist.sv */
`include "drm_map.svh"

// =============================================
// small distributed memory, async read
module drm_dist
  import drm_pkg::*;
(
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire logic                     i_we,
  input  wire logic [`DRM_DIST_AW-1:0]  i_addr,
  input  wire logic [`DRM_DIST_AW-1:0]  i_rd_addr,
  input  wire logic [`DRM_DIST_DW-1:0]  i_din,
  output logic      [`DRM_DIST_DW-1:0]  o_spo,
  output logic      [`DRM_DIST_DW-1:0]  o_dpo
);

  // storage words
  logic [`DRM_DIST_DW-1:0] mem [`DRM_DIST_WORDS];

  // =============================================
  // synchronous write on rising edge
  always_ff @(posedge i_core_clk) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_din; // R19
    end
  end

  // =============================================
  // two combinational read outputs
  assign o_spo = mem[i_addr];    // R20
  assign o_dpo = mem[i_rd_addr]; // R20

  // =============================================
  // checks
  AST_DIST_WRITE: assert property ( // R19
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && i_we |=> mem[$past(i_addr)] == $past(i_din))
    else $error("distributed write not visible");

endmodule

/* File: design/drm_map.svh */
// Function
// R01 - port A acts before port B each cycle
// R02 - port A reads old word under port B write
// R03 - user avoids cross-port same-address read/write
// R04 - global enable overrides write enable
// R05 - whole-word and per-byte write enables
// R06 - output register reset clears to zero only
// R07 - both ports share one clock
// R08 - simple dual-port: A writes, B reads
// R09 - true dual-port: both r/w, outputs hold
// R10 - single-port rf/wf realised as simple dual-port; code reads single-port through port a, b idle
// R11 - read-first shows old word while writing
// R12 - write-first shows new word while writing
// R13 - no-change holds output during own write
// R14 - per-port selectable write mode; code never applies i_mode_b: b writes only in true dual-port, forced no-change
// R15 - tile is 4K words by 72 bits
// R16 - cascade height default 8, configurable
// R17 - stages equal rows plus columns
// R18 - data width never changes stage count
// R19 - distributed memory 64x16, written on clock edge
// R20 - distributed memory two asynchronous read outputs
// R21 - block ports read synchronously, registered
// R22 - disabled port holds output, no access
`ifndef DRM_MAP_SVH
`define DRM_MAP_SVH

// =============================================
// tile geometry
`define DRM_TILE_DEPTH   4096
`define DRM_TILE_WIDTH   72
`define DRM_CASCADE_DEF  8
`define DRM_ADDR_W_DEF   13
`define DRM_BYTE_W       8

// =============================================
// output register reset (output_reset_value)
`define DRM_OUTPUT_RESET_VALUE 1'b0

// =============================================
// distributed memory geometry
`define DRM_DIST_WORDS   64
`define DRM_DIST_DW      16
`define DRM_DIST_AW      6

`endif

/* File: design/drm_pipe.sv */
// =============================================
// output pipeline registers behind a port
module drm_pipe
  import drm_pkg::*;
#(
  parameter int W      = 72,
  parameter int STAGES = 3
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  drm_pipe_if.snk           p,
  output logic [W-1:0]      o_data
);

  // whole chain of stages
  typedef struct packed {
    logic [STAGES-1:0][W-1:0] stg;
  } drm_pp_st_t;

  drm_pp_st_t st_r;    // registered chain
  drm_pp_st_t st_nxt;  // next chain

  // =============================================
  // shift one stage per enabled edge
  always_comb begin
    st_nxt = st_r;
    if (p.adv) begin
      st_nxt.stg[0] = p.data;
      for (int i = 1; i < STAGES; i++) begin
        st_nxt.stg[i] = st_r.stg[i-1];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_data = st_r.stg[STAGES-1];

  // =============================================
  // checks
  AST_PIPE_SHIFT: assert property ( // R17
    @(posedge i_core_clk) disable iff (!i_rst_n)
    p.adv |=> st_r.stg[0] == $past(p.data))
    else $error("pipeline first stage missed its input");

endmodule

/* File: design/drm_pipe_if.sv */
// =============================================
// output word handed to a pipeline chain
interface drm_pipe_if #(
  parameter int W = 72
);
  logic [W-1:0] data;  // word leaving the output register
  logic         adv;   // advance strobe (clock enable)

  modport src (output data, output adv);
  modport snk (input data, input adv);
endinterface

/* File: design/drm_pkg.sv */
`include "drm_map.svh"

package drm_pkg;

  // =============================================
  // per-port write behaviour
  typedef enum logic [1:0] {
    DRM_NO_CHANGE   = 2'h0,
    DRM_READ_FIRST  = 2'h1,
    DRM_WRITE_FIRST = 2'h3
  } drm_mode_t;

  // =============================================
  // memory arrangement
  typedef enum logic [1:0] {
    DRM_SINGLE = 2'h0,
    DRM_SIMPLE = 2'h1,
    DRM_TRUE   = 2'h3
  } drm_arr_t;

  // =============================================
  // output pipeline depth from the tile matrix
  function automatic int drm_pipe_stages(int depth, int casc);
    int tiles;
    int rows;
    int cols;
    tiles = (depth + `DRM_TILE_DEPTH - 1) / `DRM_TILE_DEPTH; // R15
    rows  = (tiles > casc) ? casc : tiles; // R16
    cols  = (tiles + casc - 1) / casc;
    return rows + cols; // R17
  endfunction

endpackage

/* File: design/drm_top.sv */
`include "drm_map.svh"

// =============================================
// dual-port memory with write modes
module drm_top
  import drm_pkg::*;
#(
  parameter int ADDR_W  = `DRM_ADDR_W_DEF,
  parameter int DATA_W  = `DRM_TILE_WIDTH,
  parameter int CASCADE = `DRM_CASCADE_DEF
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_ce,
  input  wire logic [1:0]               i_arrange,
  input  wire logic [1:0]               i_mode_a,
  input  wire logic [1:0]               i_mode_b,
  input  wire logic                     i_en_a,
  input  wire logic                     i_we_a,
  input  wire logic [DATA_W/8-1:0]      i_bwe_a,
  input  wire logic                     i_rst_out_a,
  input  wire logic [ADDR_W-1:0]        i_addr_a,
  input  wire logic [DATA_W-1:0]        i_din_a,
  output logic      [DATA_W-1:0]        o_dout_a,
  input  wire logic                     i_en_b,
  input  wire logic                     i_we_b,
  input  wire logic [DATA_W/8-1:0]      i_bwe_b,
  input  wire logic                     i_rst_out_b,
  input  wire logic [ADDR_W-1:0]        i_addr_b,
  input  wire logic [DATA_W-1:0]        i_din_b,
  output logic      [DATA_W-1:0]        o_dout_b,
  input  wire logic                     i_dist_we,
  input  wire logic [`DRM_DIST_AW-1:0]  i_dist_addr,
  input  wire logic [`DRM_DIST_AW-1:0]  i_dist_rd_addr,
  input  wire logic [`DRM_DIST_DW-1:0]  i_dist_din,
  output logic      [`DRM_DIST_DW-1:0]  o_dist_spo,
  output logic      [`DRM_DIST_DW-1:0]  o_dist_dpo
);

  // =============================================
  // geometry
  localparam int NB     = DATA_W / `DRM_BYTE_W;   // byte lanes
  localparam int DEPTH  = 1 << ADDR_W;            // words
  // width plays no part: wide words replicate the matrix
  localparam int STAGES = drm_pipe_stages(DEPTH, CASCADE); // R18

  // =============================================
  // state: the two port output registers
  typedef struct packed {
    logic [DATA_W-1:0] dout_a;  // port a output register
    logic [DATA_W-1:0] dout_b;  // port b output register
  } drm_st_t;

  drm_st_t st_r;    // registered state
  drm_st_t st_nxt;  // next state

  // storage array, matrix of tiles flattened
  logic [DATA_W-1:0] mem [DEPTH];

  // =============================================
  // helpers
  drm_arr_t          arr;     // arrangement in force
  drm_mode_t         mode_a;  // effective mode a
  drm_mode_t         mode_b;  // effective mode b
  logic [NB-1:0]     ln_a;    // lanes written by a
  logic [NB-1:0]     ln_b;    // lanes written by b
  logic              wr_a;    // a writes this cycle
  logic              wr_b;    // b writes this cycle
  logic              rd_a;    // a port active for output
  logic              rd_b;    // b port active for output
  logic              hit;     // a writes the word b reads
  logic [DATA_W-1:0] old_a;   // word at a before any write
  logic [DATA_W-1:0] new_a;   // word at a after a's write
  logic [DATA_W-1:0] seen_b;  // word at b after a's write
  logic [DATA_W-1:0] new_b;   // word at b after b's write

  // lanes written: global enable first, then word, then bytes
  function automatic logic [NB-1:0] lanes(
    input logic          en,
    input logic          we,
    input logic [NB-1:0] bwe
  );
    if (!en) begin
      return '0; // R04
    end
    return we ? '1 : bwe; // R05
  endfunction

  // merge written lanes over an old word
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] din,
    input logic [NB-1:0]     ln
  );
    logic [DATA_W-1:0] w;
    w = old;
    for (int l = 0; l < NB; l++) begin
      if (ln[l]) begin
        w[l*`DRM_BYTE_W +: `DRM_BYTE_W] =
          din[l*`DRM_BYTE_W +: `DRM_BYTE_W]; // R05
      end
    end
    return w;
  endfunction

  // true dual-port forces output holding on both ports
  function automatic drm_mode_t eff_mode(
    input drm_arr_t   a,
    input logic [1:0] m
  );
    if (a == DRM_TRUE) begin
      return DRM_NO_CHANGE; // R09
    end
    return drm_mode_t'(m); // R14
  endfunction

  // =============================================
  // port decode and collision ordering
  always_comb begin
    arr    = drm_arr_t'(i_arrange);
    mode_a = eff_mode(arr, i_mode_a);
    mode_b = eff_mode(arr, i_mode_b);
    // a writes in every arrangement
    ln_a   = lanes(i_en_a, i_we_a, i_bwe_a);
    // b writes only in true dual-port
    if (arr == DRM_TRUE) begin
      ln_b = lanes(i_en_b, i_we_b, i_bwe_b); // R09
    end else begin
      ln_b = '0; // R08
    end
    wr_a   = |ln_a;
    wr_b   = |ln_b;
    // a never reads in simple dual-port
    rd_a   = i_en_a && (arr != DRM_SIMPLE); // R08
    // b idle in single-port arrangement
    rd_b   = i_en_b && (arr != DRM_SINGLE);
    old_a  = mem[i_addr_a];
    new_a  = merge(old_a, i_din_a, ln_a);
    hit    = wr_a && (i_addr_a == i_addr_b);
    // a's write lands before b looks
    seen_b = hit ? merge(mem[i_addr_b], i_din_a, ln_a)
                 : mem[i_addr_b]; // R01
    new_b  = merge(seen_b, i_din_b, ln_b);
  end

  // =============================================
  // next output registers
  always_comb begin
    st_nxt = st_r;
    // disabled port keeps its output
    if (rd_a) begin // R22
      if (i_rst_out_a) begin
        st_nxt.dout_a = {DATA_W{`DRM_OUTPUT_RESET_VALUE}}; // R06
      end else if (!wr_a) begin
        st_nxt.dout_a = old_a; // R21
      end else begin
        unique case (mode_a)
          // old word out, a reads ahead of b
          DRM_READ_FIRST:  st_nxt.dout_a = old_a;  // R11
          DRM_WRITE_FIRST: st_nxt.dout_a = new_a;  // R12
          DRM_NO_CHANGE:   st_nxt.dout_a = st_r.dout_a; // R13
          default:         st_nxt.dout_a = st_r.dout_a;
        endcase
      end
    end
    if (rd_b) begin // R22
      if (i_rst_out_b) begin
        st_nxt.dout_b = {DATA_W{`DRM_OUTPUT_RESET_VALUE}}; // R06
      end else if (!wr_b) begin
        // b read under a's write of b's word sees the new word
        st_nxt.dout_b = seen_b; // R01
      end else begin
        unique case (mode_b)
          DRM_READ_FIRST:  st_nxt.dout_b = seen_b; // R11
          DRM_WRITE_FIRST: st_nxt.dout_b = new_b;  // R12
          DRM_NO_CHANGE:   st_nxt.dout_b = st_r.dout_b; // R13
          default:         st_nxt.dout_b = st_r.dout_b;
        endcase
      end
    end
  end

  // =============================================
  // single clock for both ports, frozen by enable
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin // R07
    if (!i_rst_n) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt; // R21
    end
  end

  // =============================================
  // storage writes: a first, b second, b wins ties
  // single-port rf/wf reads through port a, b stays idle
  always_ff @(posedge i_core_clk) begin // R10
    if (i_ce) begin
      for (int l = 0; l < NB; l++) begin
        if (ln_a[l]) begin
          mem[i_addr_a][l*`DRM_BYTE_W +: `DRM_BYTE_W] <=
            i_din_a[l*`DRM_BYTE_W +: `DRM_BYTE_W]; // R01
        end
      end
      for (int l = 0; l < NB; l++) begin
        if (ln_b[l]) begin
          mem[i_addr_b][l*`DRM_BYTE_W +: `DRM_BYTE_W] <=
            i_din_b[l*`DRM_BYTE_W +: `DRM_BYTE_W];
        end
      end
    end
  end

  // =============================================
  // output pipelines, rows plus columns deep
  drm_pipe_if #(.W(DATA_W)) pa_if ();
  drm_pipe_if #(.W(DATA_W)) pb_if ();

  assign pa_if.data = st_r.dout_a;
  assign pa_if.adv  = i_ce;
  assign pb_if.data = st_r.dout_b;
  assign pb_if.adv  = i_ce;

  drm_pipe #(.W(DATA_W), .STAGES(STAGES)) u_pipe_a ( // R17
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .p          (pa_if.snk),
    .o_data     (o_dout_a)
  );

  drm_pipe #(.W(DATA_W), .STAGES(STAGES)) u_pipe_b ( // R17
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .p          (pb_if.snk),
    .o_data     (o_dout_b)
  );

  // =============================================
  // distributed memory, reads are combinational
  drm_dist u_dist (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_ce       (i_ce),
    .i_we       (i_dist_we),
    .i_addr     (i_dist_addr),
    .i_rd_addr  (i_dist_rd_addr),
    .i_din      (i_dist_din),
    .o_spo      (o_dist_spo),
    .o_dpo      (o_dist_dpo)
  );

  // =============================================
  // checks
  AST_EN_HOLDS: assert property ( // R22
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !i_en_a |=> $stable(st_r.dout_a))
    else $error("disabled port a output moved");

  AST_GLOBAL_EN: assert property ( // R04
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && !i_en_a && i_we_a && !wr_b
    |=> mem[$past(i_addr_a)] == $past(old_a))
    else $error("write while global enable low");

  AST_RST_ZERO: assert property ( // R06
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && rd_a && i_rst_out_a |=> st_r.dout_a == '0)
    else $error("output reset did not clear to zero");

  AST_READ_FIRST: assert property ( // R11
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && rd_a && !i_rst_out_a && wr_a
      && mode_a == DRM_READ_FIRST
    |=> st_r.dout_a == $past(old_a))
    else $error("read-first did not show old word");

  AST_WRITE_FIRST: assert property ( // R12
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && rd_a && !i_rst_out_a && wr_a
      && mode_a == DRM_WRITE_FIRST
    |=> st_r.dout_a == $past(new_a))
    else $error("write-first did not show new word");

  AST_NO_CHANGE: assert property ( // R13
    @(posedge i_core_clk) disable iff (!i_rst_n)
    rd_b && !i_rst_out_b && wr_b |=> $stable(st_r.dout_b))
    else $error("no-change output moved during write");

  AST_A_BEFORE_B: assert property ( // R01
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && rd_b && !i_rst_out_b && !wr_b && hit
    |=> st_r.dout_b == $past(new_a))
    else $error("port b missed port a write");

  AST_SIMPLE_A: assert property ( // R08
    @(posedge i_core_clk) disable iff (!i_rst_n)
    arr == DRM_SIMPLE |=> $stable(st_r.dout_a))
    else $error("simple dual-port a output moved");

  AST_B_WRITE_OLD: assert property ( // R02
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_ce && rd_a && !i_rst_out_a && !wr_a && wr_b
      && i_addr_a == i_addr_b
    |=> st_r.dout_a == $past(old_a))
    else $error("port a saw port b write same cycle");

endmodule

/* File: tb/drm_user.sv */
// =============================================
// user logic driving one memory port
module drm_user #(
  parameter int AW = 13,
  parameter int DW = 72
) (
  input  wire logic          i_clk,     // shared clock
  output logic               o_en,      // port enable
  output logic               o_we,      // whole-word write
  output logic [DW/8-1:0]    o_bwe,     // byte lane writes
  output logic               o_rst_out, // output register reset
  output logic [AW-1:0]      o_addr,    // word address
  output logic [DW-1:0]      o_din      // write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle at time zero
  initial begin
    o_en      = 1'b0;
    o_we      = 1'b0;
    o_bwe     = '0;
    o_rst_out = 1'b0;
    o_addr    = '0;
    o_din     = '0;
  end

  // one request, launched just after a rising edge
  // cross-port collisions only where a scenario asks
  task automatic req(input logic en, input logic we,
                     input logic [DW/8-1:0] bwe, input logic rs,
                     input logic [AW-1:0] ad, input logic [DW-1:0] d);
    @(posedge i_clk);
    o_en      <= en;
    o_we      <= we;
    o_bwe     <= bwe;
    o_rst_out <= rs;
    if (en || we) begin
      o_addr <= ad;
      o_din  <= d;
    end else begin
      // released lines do not keep the last value
      o_addr <= ~o_addr;
      o_din  <= ~o_din;
    end
  endtask
endmodule

/* File: tb/tb_drm_top.sv */
// =============================================
// self-checking bench for the dual-port memory
module tb_drm_top
  import drm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = 13;
  localparam int DW = 72;

  logic            i_core_clk, i_rst_n, i_ce;
  logic [1:0]      i_arrange, i_mode_a, i_mode_b;
  logic            en_a, we_a, rs_a, en_b, we_b, rs_b;
  logic [DW/8-1:0] bwe_a, bwe_b;
  logic [AW-1:0]   addr_a, addr_b;
  logic [DW-1:0]   din_a, din_b, dout_a, dout_b;
  logic            i_dist_we;
  logic [5:0]      i_dist_addr, i_dist_rd_addr;
  logic [15:0]     i_dist_din, o_dist_spo, o_dist_dpo;
  int              failures, checks_done, cycles;

  // =============================================
  // design and the two port drivers
  drm_top #(.ADDR_W(AW), .DATA_W(DW), .CASCADE(8)) drm_top_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_arrange(i_arrange), .i_mode_a(i_mode_a), .i_mode_b(i_mode_b),
    .i_en_a(en_a), .i_we_a(we_a), .i_bwe_a(bwe_a),
    .i_rst_out_a(rs_a), .i_addr_a(addr_a), .i_din_a(din_a),
    .o_dout_a(dout_a), .i_en_b(en_b), .i_we_b(we_b), .i_bwe_b(bwe_b),
    .i_rst_out_b(rs_b), .i_addr_b(addr_b), .i_din_b(din_b),
    .o_dout_b(dout_b), .i_dist_we(i_dist_we), .i_dist_addr(i_dist_addr),
    .i_dist_rd_addr(i_dist_rd_addr), .i_dist_din(i_dist_din),
    .o_dist_spo(o_dist_spo), .o_dist_dpo(o_dist_dpo));
  drm_user #(.AW(AW), .DW(DW)) pa (.i_clk(i_core_clk), .o_en(en_a),
    .o_we(we_a), .o_bwe(bwe_a), .o_rst_out(rs_a), .o_addr(addr_a),
    .o_din(din_a));
  drm_user #(.AW(AW), .DW(DW)) pb (.i_clk(i_core_clk), .o_en(en_b),
    .o_we(we_b), .o_bwe(bwe_b), .o_rst_out(rs_b), .o_addr(addr_b),
    .o_din(din_b));

  // =============================================
  // clock, timeout and helpers
  initial i_core_clk = 1'b0;
  always #12.5 i_core_clk = ~i_core_clk;

  // cut a hang short
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [DW-1:0] pat(input logic [7:0] k);
    return {9{k}};
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  // release both ports, wait out the pipeline
  task automatic done();
    fork
      pa.req(1'b0, 1'b0, '0, 1'b0, '0, '0);
      pb.req(1'b0, 1'b0, '0, 1'b0, '0, '0);
    join
    wt(3);
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] ex,
                     input logic [DW-1:0] got);
    checks_done++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask

  task automatic conclude();
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // =============================================
  // scenarios
  // each write mode on port a, single-port
  task automatic t_modes();
    drm_mode_t     md[3];
    logic [DW-1:0] ex[3];
    md = '{DRM_NO_CHANGE, DRM_READ_FIRST, DRM_WRITE_FIRST};
    ex = '{pat(8'h07), pat(8'h05), pat(8'h15)};
    foreach (md[i]) begin
      i_arrange <= DRM_SINGLE;
      i_mode_a  <= md[i];
      i_mode_b  <= md[2-i];
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h5, pat(8'h05));
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h7, pat(8'h07));
      pa.req(1'b1, 1'b0, '0, 1'b0, 13'h7, '0);
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h5, pat(8'h15));
      done();
      chk("mode write out", ex[i], dout_a);
      pa.req(1'b1, 1'b0, '0, 1'b0, 13'h5, '0);
      done();
      chk("mode stored", pat(8'h15), dout_a);
    end
  endtask

  // byte lanes, enable priority, latency, output reset
  task automatic t_bytes();
    i_mode_a <= DRM_NO_CHANGE;
    pa.req(1'b1, 1'b1, '0, 1'b0, 13'h14, pat(8'haa));
    pa.req(1'b1, 1'b0, 9'h005, 1'b0, 13'h14, pat(8'h33));
    pa.req(1'b0, 1'b1, '0, 1'b0, 13'h14, pat(8'hcc));
    pa.req(1'b1, 1'b0, '0, 1'b0, 13'h14, '0);
    fork
      pa.req(1'b0, 1'b0, '0, 1'b0, '0, '0);
    join
    wt(2);
    chk("latency early", pat(8'h15), dout_a);
    wt(1);
    chk("byte merge", 72'haaaaaaaaaaaa33aa33, dout_a);
    pa.req(1'b0, 1'b0, '0, 1'b1, '0, '0);
    done();
    chk("disabled hold", 72'haaaaaaaaaaaa33aa33, dout_a);
    pa.req(1'b1, 1'b0, '0, 1'b1, 13'h14, '0);
    done();
    chk("output reset", '0, dout_a);
  endtask

  // true dual-port ordering and output holding
  task automatic t_true();
    i_arrange <= DRM_TRUE;
    i_mode_a  <= DRM_WRITE_FIRST;
    fork
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h1e, pat(8'h30));
      pb.req(1'b1, 1'b1, '0, 1'b0, 13'h1f, pat(8'h31));
    join
    fork
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h20, pat(8'h32));
      pb.req(1'b1, 1'b0, '0, 1'b0, 13'h20, '0);
    join
    fork
      pa.req(1'b1, 1'b0, '0, 1'b0, 13'h1f, '0);
      pb.req(1'b1, 1'b1, '0, 1'b0, 13'h1f, pat(8'h41));
    join
    pa.req(1'b1, 1'b1, '0, 1'b0, 13'h21, pat(8'h33));
    done();
    chk("a read under b write", pat(8'h31), dout_a);
    chk("b read after a write", pat(8'h32), dout_b);
    pa.req(1'b1, 1'b0, '0, 1'b0, 13'h1f, '0);
    done();
    chk("b write stored", pat(8'h41), dout_a);
  endtask

  // simple dual-port: a writes only, b reads only
  task automatic t_simple();
    i_arrange <= DRM_SIMPLE;
    fork
      pa.req(1'b1, 1'b1, '0, 1'b0, 13'h28, pat(8'h50));
      pb.req(1'b1, 1'b1, '0, 1'b0, 13'h28, pat(8'h60));
    join
    fork
      pa.req(1'b1, 1'b0, '0, 1'b0, 13'h28, '0);
      pb.req(1'b1, 1'b0, '0, 1'b0, 13'h28, '0);
    join
    done();
    chk("simple b read", pat(8'h50), dout_b);
    chk("simple a hold", pat(8'h41), dout_a);
  endtask

  // distributed memory, clocked write, async read
  task automatic t_dist();
    i_dist_we      <= 1'b1;
    i_dist_addr    <= 6'h03;
    i_dist_rd_addr <= 6'h03;
    i_dist_din     <= 16'hbeef;
    wt(1);
    chk("dist spo", 72'(16'hbeef), 72'(o_dist_spo));
    i_dist_addr <= 6'h04;
    i_dist_din  <= 16'h1234;
    wt(1);
    chk("dist spo 2", 72'(16'h1234), 72'(o_dist_spo));
    chk("dist dpo", 72'(16'hbeef), 72'(o_dist_dpo));
    i_dist_we   <= 1'b0;
    i_dist_addr <= 6'h03;
    i_dist_din  <= 16'h5555;
    #1;
    chk("dist async", 72'(16'hbeef), 72'(o_dist_spo));
    wt(1);
    chk("dist no write", 72'(16'hbeef), 72'(o_dist_spo));
    // frozen clock enable blocks the write
    i_ce      <= 1'b0;
    i_dist_we <= 1'b1;
    wt(1);
    chk("dist frozen", 72'(16'hbeef), 72'(o_dist_spo));
    i_ce      <= 1'b1;
    i_dist_we <= 1'b0;
    wt(1);
  endtask

  // =============================================
  // main sequence
  initial begin
    failures       = 0;
    checks_done    = 0;
    cycles         = 0;
    i_rst_n        = 1'b0;
    i_ce           = 1'b1;
    i_arrange      = DRM_SINGLE;
    i_mode_a       = DRM_NO_CHANGE;
    i_mode_b       = DRM_NO_CHANGE;
    i_dist_we      = 1'b0;
    i_dist_addr    = '0;
    i_dist_rd_addr = '0;
    i_dist_din     = '0;
    wt(20);
    chk("reset out a", '0, dout_a);
    i_rst_n <= 1'b1;
    wt(1);
    chk("reset out b", '0, dout_b);
    t_modes();
    t_bytes();
    t_true();
    t_simple();
    t_dist();
    conclude();
  end
endmodule
